/* File: hdl/sdc_conv_cfg.sv */
`timescale 1ns/1ps
module sdc_conv_cfg #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic CMD_WR,
    input wire logic [1:0] CMD_IDX,
    input wire logic [7:0] CMD_WDATA,
    output logic [7:0] CMD_RDATA,
    input wire logic OCR_WR,
    input wire logic [23:0] OCR_WDATA,
    output logic [23:0] OCR_RDATA,
    input wire logic MOD_BIT,
    input wire logic READ_BUSY,
    input wire logic READ_DONE,
    output logic RESULT_READY_N,
    output logic [23:0] CONV_RESULT,
    output logic RESULT_SETTLED,
    output logic [2:0] OP_MODE,
    output logic [2:0] GAIN_SEL,
    output logic [1:0] CHAN_SEL,
    output logic [2:0] RATE_SEL,
    output logic MOD_TICK,
    output logic SAMP_TICK,
    output logic RES_VALID,
    input wire logic RES_READY,
    output logic [23:0] RES_DATA,
    output logic RES_SETTLED
);

    // Whole state of the block
    typedef struct packed {
        sdc_pkg::sdc_cfg_t cfg;
        logic [23:0] offset_correction;
        logic [23:0] acc;
        logic [13:0] mcnt;
        sdc_pkg::sdc_rp_t rp;
        logic [4:0] pre_cnt;
        logic [23:0] pend;
        logic [1:0] settle;
        logic [23:0] result;
        logic settled;
        logic ready_n;
        logic [7:0] rdata;
        logic mod_tick;
        logic samp_tick;
    } st_t;

    st_t s_q; // Registered state
    st_t s_d; // Next state
    logic mod_tick; // Modulator result strobe
    logic samp_tick; // Input sampling strobe
    logic dsync; // Modulator count restart request
    logic conv_done; // Decimation period complete
    logic push; // Result handed to the buffer
    logic buf_ready; // Buffer has room
    logic [23:0] acc_next; // Accumulator after this tick
    logic [23:0] corr; // Correction derived from the offset word
    logic temp_mode; // Current mode is a temporary one
    sdc_pkg::sdc_word_t buf_in; // Word entering the buffer
    sdc_pkg::sdc_word_t buf_out; // Word leaving the buffer

    // Signed correction, two's complement whatever the format
    function automatic logic [23:0] ocr_to_corr(input logic [23:0] w);
        return 24'($signed(w) >>> sdc_pkg::OCR_CORR_SHIFT);
    endfunction

    // Applies correction, unipolar limit and output format
    function automatic logic [23:0] shape(input logic [23:0] raw,
                                          input logic [23:0] c,
                                          input logic uni,
                                          input logic fmt);
        logic [23:0] v;
        v = raw - c;
        if (uni && v[23]) begin
            v = 24'h000000;
        end
        if (fmt) begin
            v[23] = ~v[23];
        end
        return v;
    endfunction

    // Rate divider for modulator and sampler strobes
    sdc_rate_gen u_rate (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .rate_sel(s_q.cfg.oversample_rate_sel),
        .gain_sel(s_q.cfg.gain_sel),
        .sync_clr(dsync),
        .mod_tick(mod_tick),
        .samp_tick(samp_tick)
    );

    // Two-entry buffer on the result stream
    sdc_skid_buf #(
        .W($bits(sdc_pkg::sdc_word_t)),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_data(buf_in),
        .out_valid(RES_VALID),
        .out_ready(RES_READY),
        .out_data(buf_out)
    );

    // Conversion, configuration and result path
    always_comb begin
        s_d = s_q;
        push = 1'b0;
        buf_in.data = s_q.pend;
        buf_in.settled = (s_q.settle == 2'h0);
        dsync = CMD_WR && (CMD_IDX == sdc_pkg::CMD_BYTE_FMT) &&
            CMD_WDATA[sdc_pkg::B3_RDY_BIT];
        corr = ocr_to_corr(s_q.offset_correction);
        temp_mode = (s_q.cfg.op_mode_sel != sdc_pkg::MODE_NORMAL) &&
            (s_q.cfg.op_mode_sel != sdc_pkg::MODE_BG_CAL) &&
            (s_q.cfg.op_mode_sel != sdc_pkg::MODE_SLEEP);
        acc_next = MOD_BIT ? (s_q.acc + 24'h000001) :
            (s_q.acc - 24'h000001);
        conv_done = 1'b0;

        // Filter: one modulator result per tick, frozen in sleep
        if (mod_tick && (s_q.cfg.op_mode_sel != sdc_pkg::MODE_SLEEP)) begin
            if (s_q.mcnt >= {1'b0, s_q.cfg.decim_ratio}) begin
                conv_done = 1'b1;
                s_d.mcnt = 14'h0000;
                s_d.acc = 24'h000000;
            end else begin
                s_d.mcnt = s_q.mcnt + 14'h0001;
                s_d.acc = acc_next;
            end
        end

        // Completion: offset capture or new pending result
        if (conv_done) begin
            if (temp_mode) begin
                case (s_q.cfg.op_mode_sel)
                    sdc_pkg::MODE_SELF_CAL,
                    sdc_pkg::MODE_SYS_OFS,
                    sdc_pkg::MODE_PSEUDO: begin
                        // Offset calibration stores the measured zero
                        s_d.offset_correction = 24'(acc_next <<
                            sdc_pkg::OCR_CORR_SHIFT);
                    end
                    default: begin
                        // Full-scale and reserved just finish
                        s_d.offset_correction = s_q.offset_correction;
                    end
                endcase
                s_d.cfg.op_mode_sel = sdc_pkg::MODE_NORMAL;
            end else begin
                s_d.pend = shape(acc_next, corr, s_q.cfg.unipolar_sel,
                    s_q.cfg.format_sel);
                if (s_q.rp == sdc_pkg::RP_RUN) begin
                    if (READ_BUSY) begin
                        s_d.rp = sdc_pkg::RP_HOLD;
                    end else begin
                        s_d.rp = sdc_pkg::RP_PRE;
                        s_d.pre_cnt = 5'h00;
                        s_d.ready_n = 1'b1;
                    end
                end
            end
        end

        // Result path sequencer
        case (s_q.rp)
            sdc_pkg::RP_RUN: begin
                // Reading the result raises ready
                if (READ_DONE) begin
                    s_d.ready_n = 1'b1;
                end
            end
            sdc_pkg::RP_HOLD: begin
                // Wait for the read to end, ready not forced
                if (!READ_BUSY) begin
                    s_d.rp = sdc_pkg::RP_LOAD;
                end
            end
            sdc_pkg::RP_PRE: begin
                // Ready held high ahead of the update
                if (s_q.pre_cnt >= sdc_pkg::PRE_LAST) begin
                    s_d.rp = sdc_pkg::RP_LOAD;
                end else begin
                    s_d.pre_cnt = s_q.pre_cnt + 5'h01;
                end
            end
            sdc_pkg::RP_LOAD: begin
                // Load and announce, stalled while the buffer is full
                if (buf_ready) begin
                    push = 1'b1;
                    s_d.result = s_q.pend;
                    s_d.settled = (s_q.settle == 2'h0);
                    s_d.ready_n = 1'b0;
                    if (s_q.settle != 2'h0) begin
                        s_d.settle = s_q.settle - 2'h1;
                    end
                    s_d.rp = sdc_pkg::RP_RUN;
                end
            end
            default: begin
                s_d.rp = sdc_pkg::RP_RUN;
            end
        endcase

        // Offset correction register write
        if (OCR_WR) begin
            s_d.offset_correction = OCR_WDATA;
        end

        // Configuration byte writes
        if (CMD_WR) begin
            case (CMD_IDX)
                sdc_pkg::CMD_BYTE_DECIM_LO: begin
                    s_d.cfg.decim_ratio[7:0] = CMD_WDATA;
                end
                sdc_pkg::CMD_BYTE_RATE: begin
                    s_d.cfg.oversample_rate_sel =
                        CMD_WDATA[sdc_pkg::B1_RATE_LSB +: 3];
                    s_d.cfg.decim_ratio[12:8] =
                        CMD_WDATA[sdc_pkg::B1_DECIM_LSB +: 5];
                end
                sdc_pkg::CMD_BYTE_MODE: begin
                    s_d.cfg.op_mode_sel = sdc_pkg::sdc_mode_t'(
                        CMD_WDATA[sdc_pkg::B2_MODE_LSB +: 3]);
                    s_d.cfg.gain_sel =
                        CMD_WDATA[sdc_pkg::B2_GAIN_LSB +: 3];
                    s_d.cfg.input_chan_sel =
                        CMD_WDATA[sdc_pkg::B2_CHAN_LSB +: 2];
                    if (CMD_WDATA[sdc_pkg::B2_CHAN_LSB +: 2] !=
                        s_q.cfg.input_chan_sel) begin
                        s_d.settle = sdc_pkg::CHAN_SETTLE;
                        s_d.mcnt = 14'h0000;
                        s_d.acc = 24'h000000;
                    end
                end
                sdc_pkg::CMD_BYTE_FMT: begin
                    s_d.cfg.format_sel =
                        CMD_WDATA[sdc_pkg::B3_FMT_BIT];
                    s_d.cfg.unipolar_sel =
                        CMD_WDATA[sdc_pkg::B3_UNI_BIT];
                end
                default: begin
                    s_d.cfg = s_q.cfg;
                end
            endcase
        end

        // Restart of the current conversion
        if (dsync) begin
            s_d.mcnt = 14'h0000;
            s_d.acc = 24'h000000;
        end

        // Readback of the selected configuration byte
        case (CMD_IDX)
            sdc_pkg::CMD_BYTE_DECIM_LO: begin
                s_d.rdata = s_q.cfg.decim_ratio[7:0];
            end
            sdc_pkg::CMD_BYTE_RATE: begin
                s_d.rdata = {s_q.cfg.oversample_rate_sel,
                    s_q.cfg.decim_ratio[12:8]};
            end
            sdc_pkg::CMD_BYTE_MODE: begin
                s_d.rdata = {s_q.cfg.op_mode_sel, s_q.cfg.gain_sel,
                    s_q.cfg.input_chan_sel};
            end
            default: begin
                s_d.rdata = 8'h00;
                s_d.rdata[sdc_pkg::B3_FMT_BIT] = s_q.cfg.format_sel;
                s_d.rdata[sdc_pkg::B3_UNI_BIT] = s_q.cfg.unipolar_sel;
                s_d.rdata[sdc_pkg::B3_RDY_BIT] = s_q.ready_n;
            end
        endcase

        // Strobes re-timed for the outputs
        s_d.mod_tick = mod_tick;
        s_d.samp_tick = samp_tick;
    end

    // State register with documented defaults
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            s_q <= '0;
            s_q.cfg.op_mode_sel <= sdc_pkg::MODE_NORMAL;
            s_q.cfg.gain_sel <= sdc_pkg::GAIN_RST;
            s_q.cfg.oversample_rate_sel <= sdc_pkg::RATE_RST;
            s_q.cfg.input_chan_sel <= sdc_pkg::CHAN_RST;
            s_q.cfg.decim_ratio <= sdc_pkg::DECIM_RST;
            s_q.rp <= sdc_pkg::RP_RUN;
            s_q.ready_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from registers
    assign CMD_RDATA = s_q.rdata;
    assign OCR_RDATA = s_q.offset_correction;
    assign RESULT_READY_N = s_q.ready_n;
    assign CONV_RESULT = s_q.result;
    assign RESULT_SETTLED = s_q.settled;
    assign OP_MODE = s_q.cfg.op_mode_sel;
    assign GAIN_SEL = s_q.cfg.gain_sel;
    assign CHAN_SEL = s_q.cfg.input_chan_sel;
    assign RATE_SEL = s_q.cfg.oversample_rate_sel;
    assign MOD_TICK = s_q.mod_tick;
    assign SAMP_TICK = s_q.samp_tick;
    assign RES_DATA = buf_out.data;
    assign RES_SETTLED = buf_out.settled;

endmodule // sdc_conv_cfg

/* File: hdl/sdc_pkg.sv */
package sdc_pkg;

    // Result and correction word width
    localparam int DATA_W = 24;
    // Decimation ratio field width
    localparam int DECIM_W = 13;
    // Modulator result counter width, holds ratio plus one
    localparam int MCNT_W = 14;
    // Master clock divider behind the modulator rate
    localparam int MCLK_DIV = 128;
    localparam int DIV_W = 7;
    // Largest meaningful rate or gain code
    localparam logic [2:0] SEL_MAX = 3'h4;

    // Reset values of the configuration fields
    localparam logic [12:0] DECIM_RST = 13'h0017;
    localparam logic [2:0] GAIN_RST = 3'h0;
    localparam logic [2:0] RATE_RST = 3'h0;
    localparam logic [1:0] CHAN_RST = 2'h0;

    // Results that are flagged unsettled after a channel change
    localparam logic [1:0] CHAN_SETTLE = 2'h3;
    // Master clocks that ready stays high ahead of a result update
    localparam int PRE_UPDATE_CLKS = 24;
    localparam logic [4:0] PRE_LAST = 5'(PRE_UPDATE_CLKS - 1);
    // Right shift that turns the correction word into a correction
    localparam int OCR_CORR_SHIFT = 1;

    // Configuration byte indices
    localparam logic [1:0] CMD_BYTE_DECIM_LO = 2'h0;
    localparam logic [1:0] CMD_BYTE_RATE = 2'h1;
    localparam logic [1:0] CMD_BYTE_MODE = 2'h2;
    localparam logic [1:0] CMD_BYTE_FMT = 2'h3;
    // Field positions inside the configuration bytes
    localparam int B2_MODE_LSB = 5;
    localparam int B2_GAIN_LSB = 2;
    localparam int B2_CHAN_LSB = 0;
    localparam int B1_RATE_LSB = 5;
    localparam int B1_DECIM_LSB = 0;
    localparam int B3_FMT_BIT = 5;
    localparam int B3_UNI_BIT = 4;
    localparam int B3_RDY_BIT = 0;

    // Operating modes
    typedef enum logic [2:0] {
        MODE_NORMAL   = 3'h0,
        MODE_SELF_CAL = 3'h1,
        MODE_SYS_OFS  = 3'h2,
        MODE_SYS_FS   = 3'h3,
        MODE_PSEUDO   = 3'h4,
        MODE_BG_CAL   = 3'h5,
        MODE_SLEEP    = 3'h6,
        MODE_RSVD     = 3'h7
    } sdc_mode_t;

    // Result path states
    typedef enum logic [1:0] {
        RP_RUN  = 2'b00,
        RP_HOLD = 2'b01,
        RP_PRE  = 2'b10,
        RP_LOAD = 2'b11
    } sdc_rp_t;

    // Configuration held by the command register
    typedef struct packed {
        sdc_mode_t op_mode_sel;
        logic [2:0] gain_sel;
        logic [1:0] input_chan_sel;
        logic [2:0] oversample_rate_sel;
        logic [12:0] decim_ratio;
        logic format_sel;
        logic unipolar_sel;
    } sdc_cfg_t;

    // Result word with its channel-settled flag
    typedef struct packed {
        logic [23:0] data;
        logic settled;
    } sdc_word_t;

    // Clamps a rate or gain code to the top entry
    function automatic logic [2:0] sdc_sel_shift(input logic [2:0] code);
        return (code > SEL_MAX) ? SEL_MAX : code;
    endfunction

endpackage

/* File: hdl/sdc_rate_gen.sv */
`timescale 1ns/1ps
module sdc_rate_gen (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] rate_sel,
    input wire logic [2:0] gain_sel,
    input wire logic sync_clr,
    output logic mod_tick,
    output logic samp_tick
);

    // Divider state
    typedef struct packed {
        logic [6:0] cnt;
    } st_t;

    st_t s_q; // Registered state
    st_t s_d; // Next state
    logic [6:0] mod_last; // Last count of a modulator period
    logic [6:0] samp_last; // Last count of a sampling period
    logic [3:0] samp_sh; // Combined gain and rate shift

    // Periods shrink by the rate, and by gain for the sampler
    always_comb begin
        mod_last = 7'((sdc_pkg::MCLK_DIV >>
            sdc_pkg::sdc_sel_shift(rate_sel)) - 1);
        samp_sh = 4'(sdc_pkg::sdc_sel_shift(rate_sel)) +
            4'(sdc_pkg::sdc_sel_shift(gain_sel));
        if (samp_sh > 4'h7) begin
            samp_sh = 4'h7;
        end
        samp_last = 7'((sdc_pkg::MCLK_DIV >> samp_sh) - 1);
        mod_tick = (s_q.cnt >= mod_last);
        samp_tick = ((s_q.cnt & samp_last) == samp_last);
        s_d = s_q;
        if (sync_clr || mod_tick) begin
            s_d.cnt = 7'h00;
        end else begin
            s_d.cnt = s_q.cnt + 7'h01;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // sdc_rate_gen

/* File: hdl/sdc_skid_buf.sv */
`timescale 1ns/1ps
module sdc_skid_buf #(
    parameter int W = 25,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    // Shift buffer: the head always sits in slot zero
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [DEPTH-1:0] vld;
    } st_t;

    st_t s_q; // Registered state
    st_t s_d; // Next state
    logic push; // Word accepted on the fill side
    logic pop; // Word taken on the drain side
    logic placed; // Push already stored in this pass

    // Pop shifts down, then push fills the first free slot
    always_comb begin
        s_d = s_q;
        placed = 1'b0;
        push = in_valid && !s_q.vld[DEPTH-1];
        pop = out_ready && s_q.vld[0];
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                s_d.mem[i] = s_q.mem[i+1];
                s_d.vld[i] = s_q.vld[i+1];
            end
            s_d.vld[DEPTH-1] = 1'b0;
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (push && !placed && !s_d.vld[i]) begin
                s_d.mem[i] = in_data;
                s_d.vld[i] = 1'b1;
                placed = 1'b1;
            end
        end
    end

    // Status straight from the registers
    assign in_ready = !s_q.vld[DEPTH-1];
    assign out_valid = s_q.vld[0];
    assign out_data = s_q.mem[0];

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // sdc_skid_buf

/* File: verif/sdc_conv_cfg_checker.sv */
`timescale 1ns/1ps
module sdc_conv_cfg_checker (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic CMD_WR,
    input wire logic [1:0] CMD_IDX,
    input wire logic [7:0] CMD_RDATA,
    input wire logic OCR_WR,
    input wire logic [23:0] OCR_WDATA,
    input wire logic [23:0] OCR_RDATA,
    input wire logic READ_BUSY,
    input wire logic READ_DONE,
    input wire logic RESULT_READY_N,
    input wire logic [23:0] CONV_RESULT,
    input wire logic [2:0] OP_MODE,
    input wire logic [2:0] RATE_SEL,
    input wire logic MOD_TICK,
    input wire logic RES_VALID,
    input wire logic RES_READY,
    input wire logic [23:0] RES_DATA
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);
    // Cycles ready has been high, and cycles since the last host read
    logic [5:0] hi_q;
    logic [5:0] qt_q;
    // Saturating counters, so a long high or quiet spell never wraps round to a short count
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            hi_q <= 6'h00;
            qt_q <= 6'h00;
        end else begin
            hi_q <= RESULT_READY_N ? hi_q + {5'h00, hi_q != 6'h3f} : 6'h00;
            qt_q <= READ_BUSY ? 6'h00 : qt_q + {5'h00, qt_q != 6'h3f};
        end
    end
    a_ready_pre: assert property (
        $fell(RESULT_READY_N) && qt_q > 6'h28 |-> hi_q >= 6'h18)
        else $error("ready not high long enough before update");
    a_mode_persist: assert property (
        !$past(CMD_WR) && !$past(SYS_RST)
        && $past(OP_MODE) inside {3'h0, 3'h5, 3'h6}
        |-> OP_MODE == $past(OP_MODE))
        else $error("permanent mode changed by itself");
    a_mode_revert: assert property (
        !$past(CMD_WR) && !$past(SYS_RST) && $changed(OP_MODE)
        |-> OP_MODE == 3'h0)
        else $error("mode changed by itself to other than normal");
    a_tick_gap: assert property (
        MOD_TICK && RATE_SEL == 3'h4 && !CMD_WR
        |=> ((!MOD_TICK) [*7] ##1 MOD_TICK) or (##[0:8] CMD_WR))
        else $error("modulator tick spacing wrong");
    a_result_load: assert property (
        $changed(CONV_RESULT) |-> !RESULT_READY_N)
        else $error("result changed without ready low");
    a_done_raise: assert property (
        READ_DONE |=> RESULT_READY_N)
        else $error("ready not raised after read");
    a_ocr_write: assert property (
        OCR_WR |=> OCR_RDATA == $past(OCR_WDATA))
        else $error("offset word not written");
    a_status_mirror: assert property (
        !$past(SYS_RST) && $past(CMD_IDX) == 2'h3
        && $stable(RESULT_READY_N) |-> CMD_RDATA[0] == RESULT_READY_N)
        else $error("ready status bit differs from pin");
    a_stream_hold: assert property (
        RES_VALID && !RES_READY |=> RES_VALID && $stable(RES_DATA))
        else $error("stream word dropped while stalled");
endmodule // sdc_conv_cfg_checker

bind sdc_conv_cfg sdc_conv_cfg_checker sdc_conv_cfg_checker_inst (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CMD_WR(CMD_WR),
    .CMD_IDX(CMD_IDX), .CMD_RDATA(CMD_RDATA), .OCR_WR(OCR_WR),
    .OCR_WDATA(OCR_WDATA), .OCR_RDATA(OCR_RDATA), .READ_BUSY(READ_BUSY),
    .READ_DONE(READ_DONE), .RESULT_READY_N(RESULT_READY_N),
    .CONV_RESULT(CONV_RESULT), .OP_MODE(OP_MODE), .RATE_SEL(RATE_SEL),
    .MOD_TICK(MOD_TICK), .RES_VALID(RES_VALID), .RES_READY(RES_READY),
    .RES_DATA(RES_DATA)
);

/* File: verif/sdc_host_model.sv */
`timescale 1ns/1ps
module sdc_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic res_valid,
    input wire logic [23:0] res_data,
    input wire logic res_settled,
    output logic res_ready,
    output logic [23:0] last_q,
    output int pops_q
);
    // Host pulls results; it may leave them unread, so the buffer fills and holds them
    always_ff @(posedge clk) begin
        if (rst) begin
            res_ready <= 1'b0;
            last_q <= 24'h000000;
            pops_q <= 0;
        end else begin
            res_ready <= !stall;
            if (res_valid && res_ready) begin
                pops_q <= pops_q + 1;
                // Words taken before the channel settles are ignored
                if (res_settled) begin
                    last_q <= res_data;
                end
            end
        end
    end
endmodule // sdc_host_model

/* File: verif/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_fail++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic SYS_CLK, SYS_RST, CMD_WR, OCR_WR, MOD_BIT, READ_BUSY, READ_DONE;
    logic RESULT_READY_N, RESULT_SETTLED, MOD_TICK, SAMP_TICK, RES_VALID;
    logic RES_READY, RES_SETTLED, stall;
    logic [1:0] CMD_IDX, CHAN_SEL;
    logic [2:0] OP_MODE, GAIN_SEL, RATE_SEL;
    logic [7:0] CMD_WDATA, CMD_RDATA;
    logic [23:0] OCR_WDATA, OCR_RDATA, CONV_RESULT, RES_DATA, last_w;
    int n_fail, num_checks, cyc, n, pops;
    // Offset, format byte, modulator level and expected result per row
    logic [23:0] ocr_t [7] = '{0, 0, 0, 0, 0, 24'h8, 24'hfffff8};
    logic [7:0] b3_t [7] = '{8'h01, 8'h20, 8'h10, 8'h0, 8'h30, 8'h0, 8'h0};
    logic mod_t [7] = '{1, 1, 0, 0, 0, 1, 1};
    logic [23:0] exp_t [7] = '{24'h14, 24'h800014, 24'h0, 24'hffffec,
        24'h800000, 24'h10, 24'h18};
    logic [2:0] tm_t [5] = '{3'h3, 3'h7, 3'h2, 3'h4, 3'h1};
    sdc_conv_cfg #(.BUF_DEPTH(2)) sdc_conv_cfg_inst (
        .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CMD_WR(CMD_WR),
        .CMD_IDX(CMD_IDX), .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA),
        .OCR_WR(OCR_WR), .OCR_WDATA(OCR_WDATA), .OCR_RDATA(OCR_RDATA),
        .MOD_BIT(MOD_BIT), .READ_BUSY(READ_BUSY), .READ_DONE(READ_DONE),
        .RESULT_READY_N(RESULT_READY_N), .CONV_RESULT(CONV_RESULT),
        .RESULT_SETTLED(RESULT_SETTLED), .OP_MODE(OP_MODE),
        .GAIN_SEL(GAIN_SEL), .CHAN_SEL(CHAN_SEL), .RATE_SEL(RATE_SEL),
        .MOD_TICK(MOD_TICK), .SAMP_TICK(SAMP_TICK), .RES_VALID(RES_VALID),
        .RES_READY(RES_READY), .RES_DATA(RES_DATA),
        .RES_SETTLED(RES_SETTLED));
    sdc_host_model sdc_host_model_inst (.clk(SYS_CLK), .rst(SYS_RST),
        .stall(stall), .res_valid(RES_VALID), .res_data(RES_DATA),
        .res_settled(RES_SETTLED), .res_ready(RES_READY), .last_q(last_w),
        .pops_q(pops));
    // Configuration byte write, one strobe cycle
    task automatic cfg_wr(input logic [1:0] i, input logic [7:0] d);
        @(posedge SYS_CLK);
        CMD_WR <= 1'b1;
        CMD_IDX <= i;
        CMD_WDATA <= d;
        @(posedge SYS_CLK);
        CMD_WR <= 1'b0;
    endtask
    // Select a byte and let the registered readback settle
    task automatic cfg_rd(input logic [1:0] i);
        @(posedge SYS_CLK);
        CMD_IDX <= i;
        repeat (2) @(posedge SYS_CLK);
        #1;
    endtask
    task automatic ocr_wr(input logic [23:0] d);
        @(posedge SYS_CLK);
        OCR_WR <= 1'b1;
        OCR_WDATA <= d;
        @(posedge SYS_CLK);
        OCR_WR <= 1'b0;
    endtask
    // Wait k falls of ready; cyc ends as the last interval in cycles
    task automatic wait_rdy(input int k);
        repeat (k) begin
            cyc = 0;
            do begin
                @(negedge SYS_CLK);
                cyc++;
            end while (RESULT_READY_N !== 1'b1 && cyc < 5000);
            while (RESULT_READY_N !== 1'b0 && cyc < 5000) begin
                @(negedge SYS_CLK);
                cyc++;
            end
        end
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // 25 MHz master clock
    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end
    // Hang guard
    initial begin
        repeat (80000) @(posedge SYS_CLK);
        n_fail++;
        $display("[ERR] watchdog exp done got timeout");
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {SYS_RST, CMD_WR, CMD_IDX, CMD_WDATA, OCR_WR, OCR_WDATA} = '0;
        SYS_RST = 1'b1;
        {MOD_BIT, READ_BUSY, READ_DONE, stall} = 4'h8;
        repeat (10) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        cfg_rd(0);
        `CHK("decim lo", 8'h17, CMD_RDATA)
        cfg_rd(3);
        `CHK("ready bit", 1'b1, CMD_RDATA[0])
        `CHK("mode", 3'h0, OP_MODE)
        `CHK("offset", 24'h0, OCR_RDATA)
        `CHK("gain", 3'h0, GAIN_SEL)
        note("reset");
        for (int g = 0; g < 5; g++) begin
            cfg_wr(2, {3'h0, g[2:0], 2'h0});
            cfg_rd(2);
            `CHK("gain rd", {3'h0, g[2:0], 2'h0}, CMD_RDATA)
            `CHK("gain", g[2:0], GAIN_SEL)
        end
        cfg_wr(2, 8'h00);
        cfg_wr(0, 8'h13);
        for (int r = 0; r < 5; r++) begin
            cfg_wr(1, {r[2:0], 5'h00});
            wait_rdy(2);
            `CHK("rate", r[2:0], RATE_SEL)
            `CHK("period", 2560 >> r, cyc)
        end
        note("rates");
        cfg_wr(1, 8'h40);
        cfg_wr(2, 8'h08);
        @(posedge SYS_CLK);
        n = 0;
        cyc = 0;
        repeat (160) begin
            @(negedge SYS_CLK);
            n += SAMP_TICK;
            cyc += MOD_TICK;
        end
        `CHK("samp ticks", 20, n)
        `CHK("mod ticks", 5, cyc)
        cfg_wr(2, 8'h00);
        cfg_wr(1, 8'h80);
        note("ticks");
        cfg_wr(2, 8'ha0);
        wait_rdy(2);
        `CHK("bg mode", 3'h5, OP_MODE)
        cfg_wr(2, 8'hc0);
        repeat (400) @(posedge SYS_CLK);
        `CHK("sleep", 3'h6, OP_MODE)
        foreach (tm_t[i]) begin
            cfg_wr(2, {tm_t[i], 5'h00});
            wait_rdy(2);
            `CHK("revert", 3'h0, OP_MODE)
        end
        `CHK("cal offset", 24'h28, OCR_RDATA)
        `CHK("cal result", 24'h0, CONV_RESULT)
        note("modes");
        foreach (exp_t[i]) begin
            ocr_wr(ocr_t[i]);
            cfg_wr(3, b3_t[i]);
            MOD_BIT <= mod_t[i];
            wait_rdy(2);
            `CHK("ocr rd", ocr_t[i], OCR_RDATA)
            `CHK("result", exp_t[i], CONV_RESULT)
        end
        `CHK("stream", 24'h18, last_w)
        ocr_wr(24'h0);
        note("results");
        wait_rdy(2);
        @(posedge SYS_CLK);
        READ_BUSY <= 1'b1;
        n = 0;
        repeat (200) begin
            @(negedge SYS_CLK);
            n += RESULT_READY_N;
        end
        `CHK("busy ready", 0, n)
        @(posedge SYS_CLK);
        READ_BUSY <= 1'b0;
        repeat (5) @(posedge SYS_CLK);
        READ_DONE <= 1'b1;
        @(posedge SYS_CLK);
        READ_DONE <= 1'b0;
        repeat (2) @(negedge SYS_CLK);
        `CHK("done ready", 1'b1, RESULT_READY_N)
        `CHK("held result", 24'h14, CONV_RESULT)
        note("read");
        @(posedge SYS_CLK);
        stall <= 1'b1;
        wait_rdy(2);
        repeat (400) @(negedge SYS_CLK);
        n = pops;
        `CHK("stall valid", 1'b1, RES_VALID)
        @(posedge SYS_CLK);
        stall <= 1'b0;
        repeat (10) @(negedge SYS_CLK);
        `CHK("pops", n + 3, pops)
        note("buffer");
        cfg_wr(2, 8'h01);
        @(negedge SYS_CLK);
        `CHK("chan", 2'h1, CHAN_SEL)
        for (int k = 1; k < 5; k++) begin
            wait_rdy(1);
            `CHK("settled", k == 4, RESULT_SETTLED)
        end
        note("channel");
        tally_and_finish();
    end
endmodule // tb
